// file: tb/crbs_checker.sv
// port assertions for the boot sequencer
`timescale 1ns/10ps
module crbs_checker (
  input wire clk_in, rst_in, bus_grant_in, bus_ack_in, bus_access_err_in, // inputs
  input wire bus_addr_err_in, bus_req_out, fetch_start_out, running_out, halted_out, // core
  input wire supervisor_flag_out, // status
  input wire [2:0] interrupt_priority_mask_out, // mask
  input wire [31:0] bus_rdata_in, bus_addr_out, fetch_pc_out, stack_ptr_out, // vectors
  input wire [31:0] vector_base_out, core_feature_word_out // registers
);
  wire err = bus_access_err_in | bus_addr_err_in; // either fault kind
  // one domain; nothing is judged while reset is held
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_rst; $fell(rst_in) |-> supervisor_flag_out && !bus_req_out &&
    interrupt_priority_mask_out == 3'h7; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_vb; $fell(rst_in) |=> vector_base_out == 32'h0; endproperty
  a_vb: assert property (p_vb) else $error("vector base");
  property p_req; $rose(bus_req_out) |-> $past(bus_grant_in) && bus_addr_out == 32'h0;
  endproperty
  a_req: assert property (p_req) else $error("request");
  property p_sp; bus_ack_in && !err && bus_req_out && bus_addr_out == 32'h0 |=>
    bus_req_out && bus_addr_out == 32'h4 && stack_ptr_out == $past(bus_rdata_in); endproperty
  a_sp: assert property (p_sp) else $error("stack pointer");
  property p_pc; bus_ack_in && !err && bus_req_out && bus_addr_out == 32'h4 |=>
    fetch_start_out && fetch_pc_out == $past(bus_rdata_in) ##1 !fetch_start_out; endproperty
  a_pc: assert property (p_pc) else $error("start pc");
  property p_err; err && !running_out |=> halted_out && !bus_req_out; endproperty
  a_err: assert property (p_err) else $error("no halt");
  property p_halt; halted_out |=> halted_out && !running_out; endproperty
  a_halt: assert property (p_halt) else $error("halt left");
  property p_ro; $past(rst_in, 2) == 1'b0 |-> $stable(core_feature_word_out); endproperty
  a_ro: assert property (p_ro) else $error("feature word");
endmodule // crbs_checker
bind crbs_core_reset_boot_sequencer crbs_checker chk (.*);

// file: tb/crbs_core_reset_boot_sequencer_test.sv
// bench for the boot sequencer
`timescale 1ns/10ps
module crbs_core_reset_boot_sequencer_test;
  reg clk_in = 0, rst_in = 1, bus_grant_in = 0, bus_access_err_in = 0, bus_addr_err_in = 0;
  reg insn_done_in = 0, dbg_sel_in = 0;
  reg [3:0] w = 0;
  wire bus_req_out, bus_ack_in, fetch_start_out, running_out, halted_out, local_mem_enable_out;
  wire supervisor_flag_out, trace_flag_out, master_state_flag_out;
  wire [2:0] interrupt_priority_mask_out;
  wire [31:0] bus_rdata_in, bus_addr_out, fetch_pc_out, vector_base_out, stack_ptr_out;
  wire [31:0] core_feature_word_out, local_memory_size_word_out, dbg_rdata_out;
  integer num_errors = 0, tests_run = 0, cyc = 0, i;
  crbs_core_reset_boot_sequencer DUT (.*);
  crbs_vec_mem mem (.clk_in(clk_in), .req_in(bus_req_out), .addr_in(bus_addr_out), .wait_in(w),
    .ack_out(bus_ack_in), .data_out(bus_rdata_in));
  initial forever #10 clk_in = ~clk_in;
  // hang guard, far past the hundred or so cycles the run needs
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      num_errors = num_errors + 1;
      final_report;
    end
  end
  task check(input [35:0] seen, input [35:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch %0t: %h not %h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      if (num_errors == 0 && tests_run > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // reset four cycles, check the release state, then grant the bus
  task start(input [3:0] ws);
    begin
      {w, rst_in, bus_grant_in} = {ws, 2'b10};
      repeat (4) @(negedge clk_in);
      check({supervisor_flag_out, trace_flag_out, master_state_flag_out,
        interrupt_priority_mask_out, local_mem_enable_out, bus_req_out, halted_out}, 9'h138);
      rst_in = 0;
      repeat (2) @(negedge clk_in);
      check({vector_base_out, bus_req_out}, 33'h0);
      check(core_feature_word_out, 32'h5a348067);
      check(local_memory_size_word_out, 32'h00401070);
      bus_grant_in = 1;
    end
  endtask
  // boot to running; a fault once running is ignored; debug port reads the memory word
  task boot(input [3:0] ws);
    begin
      start(ws);
      for (i = 0; i < 40 && fetch_start_out !== 1'b1; i = i + 1)
        @(negedge clk_in);
      check({bus_req_out, fetch_pc_out}, {1'b0, 32'h410});
      check(stack_ptr_out, 32'h20000ff0);
      {insn_done_in, dbg_sel_in} = 2'b11;
      @(negedge clk_in);
      {insn_done_in, bus_access_err_in} = 2'b01;
      check(dbg_rdata_out, 32'h00401070);
      @(negedge clk_in);
      {bus_access_err_in, dbg_sel_in} = 2'b00;
      check({running_out, halted_out, fetch_start_out}, 3'h4);
    end
  endtask
  // fault during the stack read or the first-instruction wait halts until reset
  task fault(input [1:0] k);
    begin
      start(3);
      for (i = 0; i < 40 && (k[1] ? fetch_start_out : bus_req_out) !== 1'b1; i = i + 1)
        @(negedge clk_in);
      {bus_addr_err_in, bus_access_err_in} = {k[0], !k[0]};
      @(negedge clk_in);
      {bus_addr_err_in, bus_access_err_in, insn_done_in} = 3'h1;
      repeat (3) @(negedge clk_in);
      insn_done_in = 0;
      check({halted_out, running_out, bus_req_out}, 3'h4);
    end
  endtask
  initial begin
    boot(0);
    fault(0);
    fault(1);
    fault(2);
    fault(3);
    boot(5);
    final_report;
  end
endmodule // crbs_core_reset_boot_sequencer_test

// file: tb/crbs_vec_mem.sv
// vector memory answering longword reads
`timescale 1ns/10ps
module crbs_vec_mem (
  input wire clk_in, // core clock
  input wire req_in, // read request
  input wire [31:0] addr_in, // read address
  input wire [3:0] wait_in, // wait cycles per read
  output reg ack_out = 1'b0, // read complete
  output reg [31:0] data_out = 32'h0 // read data
);
  reg [3:0] cnt_reg = 4'h0;
  wire hit = req_in && !ack_out && cnt_reg == wait_in; // answer due
  // idle data is inverted each cycle so a stale word never passes as valid
  always @(negedge clk_in) begin
    ack_out <= hit;
    cnt_reg <= (req_in && !ack_out && !hit) ? cnt_reg + 4'h1 : 4'h0;
    data_out <= hit ? (addr_in[2] ? 32'h410 : 32'h20000ff0) : ~data_out;
  end
endmodule // crbs_vec_mem

// file: verilog/crbs_consts.vh
// constants for the core reset and boot sequencer
`ifndef CRBS_CONSTS_VH
`define CRBS_CONSTS_VH
`define CRBS_SP_VEC_ADDR 32'h00000000
`define CRBS_PC_VEC_ADDR 32'h00000004
`define CRBS_VBASE_RST 32'h00000000
`define CRBS_IPM_MAX 3'h7
`define CRBS_FAMILY_MSB 31
`define CRBS_FAMILY_LSB 24
`define CRBS_VER_MSB 23
`define CRBS_VER_LSB 20
`define CRBS_REV_MSB 19
`define CRBS_REV_LSB 16
`define CRBS_ISA_MSB 7
`define CRBS_ISA_LSB 4
`define CRBS_DBG_MSB 3
`define CRBS_DBG_LSB 0
`define CRBS_MAC_BIT 15
`define CRBS_DIV_BIT 14
`define CRBS_ENHANCED_MULT_ACC_PRESENT_FLAG_BIT 13
`define CRBS_FPU_BIT 12
`define CRBS_FLASH_MSB 23
`define CRBS_FLASH_LSB 19
`define CRBS_RAM_MSB 7
`define CRBS_RAM_LSB 3
`define CRBS_MEM_RSVD_MSB 15
`define CRBS_MEM_RSVD_LSB 8
`define CRBS_MEM_RSVD_VAL 8'h10
`define CRBS_FLASH_NONE 5'h00
`define CRBS_FLASH_64K 5'h08
`define CRBS_FLASH_512K 5'h0b
`define CRBS_RAM_NONE 5'h00
`define CRBS_RAM_512B 5'h02
`define CRBS_RAM_32K 5'h0e
`define CRBS_RAM_128K 5'h12
`endif

// file: verilog/crbs_core_reset_boot_sequencer.v
// reset exception and boot vector fetch sequencer of the processor core
// Overview of operation
// (RULE1) reset outranks all exceptions and abandons work in progress unrecoverably.
// (RULE2) reset sets supervisor flag and clears trace flag.
// (RULE3) reset clears master state flag and sets interrupt mask to seven.
// (RULE4) vector base written to zero after status register initialisation.
// (RULE5) reset disables control registers of core-local memories.
// (RULE6) after bus grant read word 0 into stack pointer, word 4 into pc.
// (RULE7) then fetch first instruction from loaded pc and run.
// (RULE8) access or address error before first instruction completes halts in double fault.
// (RULE9) after reset release load feature word and memory size word into data registers.
// (RULE10) feature word top byte is a fixed read-only family code.
// (RULE11) feature word holds fixed version and revision nibbles below family field.
// (RULE12) bits 15..12 are unit presence flags; divider, enhanced_mult_acc_present_flag, float read zero.
// (RULE13) bits 7..4 instruction set revision, 3..0 debug revision; 11..8 reserved.
// (RULE14) memory word bits 23..19 flash size, bits 7..3 sram size.
// (RULE15) sram codes: 0 none, 2 is 512 bytes, doubling to 0e, 12 is 128k.
// (RULE16) memory word bits 15..8 reset to fixed pattern, other reserved bits zero.
// (RULE17) debugger reads both configuration data registers, read only.
// (RULE18) double fault halt persists until a new reset.
// (RULE19) while reset held, hold state and issue no bus cycles.
`timescale 1ns/10ps
`include "crbs_consts.vh"

module crbs_core_reset_boot_sequencer #(
  parameter [7:0] FAMILY_CODE = 8'h5a, // arbitrary identification value
  parameter [3:0] VERSION_CODE = 4'h3, // arbitrary identification value
  parameter [3:0] REVISION_CODE = 4'h4, // arbitrary identification value
  parameter [3:0] ISA_CODE = 4'h6, // arbitrary identification value
  parameter [3:0] DEBUG_CODE = 4'h7, // arbitrary identification value
  parameter MAC_PRESENT = 1'b1, // multiply-accumulate unit fitted
  parameter [4:0] FLASH_SIZE_CODE = 5'h08, // flash size code
  parameter [4:0] RAM_SIZE_CODE = 5'h0e // sram size code
) (
  input wire clk_in, // core clock, 50 MHz
  input wire rst_in, // synchronous reset, active high
  input wire bus_grant_in, // bus granted to the core
  input wire [31:0] bus_rdata_in, // read data from memory
  input wire bus_ack_in, // read cycle complete
  input wire bus_access_err_in, // access error on current cycle
  input wire bus_addr_err_in, // address error on current cycle
  input wire insn_done_in, // first instruction completed by execution
  input wire dbg_sel_in, // debug port selects word: 0 feature, 1 memory
  output reg bus_req_out, // read cycle request, held across both vector reads until the pc vector ack or an error
  output reg [31:0] bus_addr_out, // read address
  output reg [31:0] fetch_pc_out, // address of instruction to fetch
  output reg fetch_start_out, // one-cycle pulse: begin execution
  output reg running_out, // normal execution under way
  output reg halted_out, // double fault halt
  output reg supervisor_flag_out, // status supervisor flag
  output reg trace_flag_out, // status trace flag
  output reg master_state_flag_out, // status master state flag
  output reg [2:0] interrupt_priority_mask_out, // status interrupt mask
  output reg [31:0] vector_base_out, // vector base register
  output reg local_mem_enable_out, // local memory control enable
  output reg [31:0] stack_ptr_out, // supervisor stack pointer
  output reg [31:0] core_feature_word_out, // data register zero
  output reg [31:0] local_memory_size_word_out, // data register one
  output reg [31:0] dbg_rdata_out // debug port read data
);

  localparam [2:0] ST_INIT = 3'h0;
  localparam [2:0] ST_WAIT_GRANT = 3'h1;
  localparam [2:0] ST_FETCH_SP = 3'h2;
  localparam [2:0] ST_FETCH_PC = 3'h3;
  localparam [2:0] ST_FIRST = 3'h4;
  localparam [2:0] ST_RUN = 3'h5;
  localparam [2:0] ST_HALT = 3'h6;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  wire [31:0] feature_word;
  wire [31:0] memsize_word;
  wire bus_err;

  // fixed configuration words; unit flags for divider, enhanced_mult_acc_present_flag, float wired to zero
  assign feature_word = {FAMILY_CODE, VERSION_CODE, REVISION_CODE, // RULE10 RULE11
                         MAC_PRESENT, 1'b0, 1'b0, 1'b0, // RULE12
                         4'h0, ISA_CODE, DEBUG_CODE}; // RULE13
  assign memsize_word = {8'h00, FLASH_SIZE_CODE, 3'h0, // RULE14
                         `CRBS_MEM_RSVD_VAL, RAM_SIZE_CODE, 3'h0}; // RULE15 RULE16
  assign bus_err = bus_access_err_in | bus_addr_err_in;

  // boot sequence; any error during the vector reads or the first-instruction wait ends in halt
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_INIT: begin
        state_next = ST_WAIT_GRANT; // RULE4 vector base cleared after status init
      end
      ST_WAIT_GRANT: begin
        if (bus_grant_in) begin
          state_next = ST_FETCH_SP; // RULE6
        end
      end
      ST_FETCH_SP: begin
        if (bus_err) begin
          state_next = ST_HALT; // RULE8
        end else if (bus_ack_in) begin
          state_next = ST_FETCH_PC;
        end
      end
      ST_FETCH_PC: begin
        if (bus_err) begin
          state_next = ST_HALT; // RULE8
        end else if (bus_ack_in) begin
          state_next = ST_FIRST; // RULE7
        end
      end
      ST_FIRST: begin
        if (bus_err) begin
          state_next = ST_HALT; // RULE8
        end else if (insn_done_in) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        state_next = ST_RUN;
      end
      ST_HALT: begin
        state_next = ST_HALT; // RULE18 only reset leaves
      end
      default: begin
        state_next = ST_HALT;
      end
    endcase
  end

  // state and outputs; reset wins over everything and drops all bus activity
  always @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= ST_INIT; // RULE1
      bus_req_out <= 1'b0; // RULE19
      bus_addr_out <= `CRBS_SP_VEC_ADDR;
      fetch_pc_out <= 32'h00000000;
      fetch_start_out <= 1'b0;
      running_out <= 1'b0;
      halted_out <= 1'b0;
      supervisor_flag_out <= 1'b1; // RULE2
      trace_flag_out <= 1'b0; // RULE2
      master_state_flag_out <= 1'b0; // RULE3
      interrupt_priority_mask_out <= `CRBS_IPM_MAX; // RULE3
      vector_base_out <= 32'hffffffff;
      local_mem_enable_out <= 1'b0; // RULE5
      stack_ptr_out <= 32'h00000000;
      core_feature_word_out <= 32'h00000000;
      local_memory_size_word_out <= 32'h00000000;
      dbg_rdata_out <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      fetch_start_out <= 1'b0;
      // debug port sees the data registers as read only
      dbg_rdata_out <= dbg_sel_in ? local_memory_size_word_out
                                  : core_feature_word_out; // RULE17
      case (state_reg)
        ST_INIT: begin
          vector_base_out <= `CRBS_VBASE_RST; // RULE4
          core_feature_word_out <= feature_word; // RULE9
          local_memory_size_word_out <= memsize_word; // RULE9
        end
        ST_WAIT_GRANT: begin
          if (bus_grant_in) begin
            bus_req_out <= 1'b1; // RULE6
            bus_addr_out <= `CRBS_SP_VEC_ADDR;
          end
        end
        ST_FETCH_SP: begin
          if (bus_err) begin
            bus_req_out <= 1'b0;
            halted_out <= 1'b1; // RULE8
          end else if (bus_ack_in) begin
            stack_ptr_out <= bus_rdata_in; // RULE6
            bus_addr_out <= `CRBS_PC_VEC_ADDR;
          end
        end
        ST_FETCH_PC: begin
          if (bus_err) begin
            bus_req_out <= 1'b0;
            halted_out <= 1'b1; // RULE8
          end else if (bus_ack_in) begin
            bus_req_out <= 1'b0;
            fetch_pc_out <= bus_rdata_in; // RULE6 RULE7
            fetch_start_out <= 1'b1; // RULE7
          end
        end
        ST_FIRST: begin
          if (bus_err) begin
            halted_out <= 1'b1; // RULE8
          end else if (insn_done_in) begin
            running_out <= 1'b1;
          end
        end
        default: begin
          bus_req_out <= 1'b0;
        end
      endcase
    end
  end

endmodule // crbs_core_reset_boot_sequencer
